//--- inc/cel_pkg.sv
`default_nettype none
package cel_pkg;
	// ----------------------------------------
	// record layout and sizes
	// ----------------------------------------
	localparam int CEL_LOCAL_W = 63;
	localparam int CEL_LINK_W  = 32;
	localparam int CEL_MON_W   = 96;
	localparam int CEL_TS_W    = 32;
	localparam int CEL_REC_W   = CEL_TS_W + CEL_MON_W;
	localparam int CEL_DEPTH   = 2048;
	localparam int CEL_MTF_POS = 63;
	localparam int CEL_LINK_POS = 64;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CEL_CLK_PERIOD_NS = 100;
	localparam int CEL_DETECT_NS     = 1000;
	localparam int CEL_DETECT_CYC    = (CEL_DETECT_NS / CEL_CLK_PERIOD_NS < 1) ? 1
		: CEL_DETECT_NS / CEL_CLK_PERIOD_NS;
	localparam int CEL_SHOT_CLK_HZ   = 1000000;
	// ----------------------------------------
	// main loop states
	// ----------------------------------------
	typedef enum logic [0:0] {
		CEL_POLL  = 1'b0,
		CEL_STORE = 1'b1
	} cel_state_type;
endpackage
`default_nettype wire

//--- inc/cel_store_if.sv
`timescale 1ns/1ns
`default_nettype none
interface cel_store_if #(
	parameter int AW = 11,
	parameter int RW = 128
);
	logic          wr_en;
	logic [AW-1:0] wr_addr;
	logic [RW-1:0] wr_data;
	logic          rd_en;
	logic [AW-1:0] rd_addr;
	logic [RW-1:0] rd_data;
	modport ctl (output wr_en, wr_addr, wr_data, rd_en, rd_addr, input rd_data);
	modport mem (input wr_en, wr_addr, wr_data, rd_en, rd_addr, output rd_data);
endinterface
`default_nettype wire

//--- rtl/cel_store.sv
`timescale 1ns/1ns
`default_nettype none
module cel_store
	import cel_pkg::*;
#(
	parameter int DEPTH = CEL_DEPTH
)(
	// clock and reset
	input  wire logic clock_i,
	input  wire logic sys_rst_i,
	// record port
	cel_store_if.mem  bus
);
	logic [CEL_REC_W-1:0] mem_q [DEPTH];
	logic [CEL_REC_W-1:0] rd_q;

	// no reset on the array: contents are only valid below the event count
	always_ff @(posedge clock_i) begin
		if (bus.wr_en) begin
			mem_q[bus.wr_addr] <= bus.wr_data;
		end
	end

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rd_q <= '0;
		end else if (bus.rd_en) begin
			rd_q <= mem_q[bus.rd_addr];
		end
	end

	assign bus.rd_data = rd_q;
endmodule
`default_nettype wire

//--- rtl/cel_logger.sv
// Contract
// - log event when any of 96 inputs changes
// - timestamp counts external 1 MHz shot clock
// - record holds full snapshot plus 32-bit stamp
// - 2048 records stored in arrival order
// - change detected within about one microsecond
// - shared bits feed 32-channel controller link
// - heartbeat relayed only by polled main loop
// - master thermal fault is a monitored input
`timescale 1ns/1ns
`default_nettype none
module cel_logger
	import cel_pkg::*;
#(
	parameter int DEPTH = CEL_DEPTH,
	localparam int AW   = $clog2(DEPTH)
)(
	// clock and reset
	input  wire logic                   clock_i,
	input  wire logic                   sys_rst_i,
	// monitored pins
	input  wire logic [CEL_LOCAL_W-1:0] status_i,
	input  wire logic                   master_thermal_fault_n_i,
	// controller link
	input  wire logic [CEL_LINK_W-1:0]  link_rx_i,
	output logic      [CEL_LINK_W-1:0]  link_tx_o,
	// shot timing
	input  wire logic                   shot_clk_i,
	input  wire logic                   shot_active_i,
	// heartbeat
	input  wire logic                   heartbeat_i,
	output logic                        heartbeat_o,
	// readout
	input  wire logic                   rd_en_i,
	input  wire logic [AW-1:0]          rd_addr_i,
	output logic                        rd_valid_o,
	output logic      [CEL_REC_W-1:0]   rd_data_o,
	output logic      [AW:0]            event_count_o,
	output logic                        overflow_o
);
	// ----------------------------------------
	// parameter check
	// ----------------------------------------
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("DEPTH must be a power of two, at least 2");
	end

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	localparam int RAW_W = CEL_MON_W + 3;
	logic [RAW_W-1:0]     raw;
	logic [RAW_W-1:0]     meta_q;
	logic [RAW_W-1:0]     sync_q;
	logic [CEL_MON_W-1:0] mon;
	logic                 shot_clk_s;
	logic                 shot_act_s;
	logic                 hb_s;

	// thermal fault kept at its own polarity in the snapshot
	assign raw = {heartbeat_i, shot_active_i, shot_clk_i, link_rx_i, master_thermal_fault_n_i, status_i};

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= raw;
			sync_q <= meta_q;
		end
	end

	assign mon        = sync_q[CEL_MON_W-1:0];
	assign shot_clk_s = sync_q[CEL_MON_W];
	assign shot_act_s = sync_q[CEL_MON_W+1];
	assign hb_s       = sync_q[CEL_MON_W+2];

	// ----------------------------------------
	// shot timebase
	// ----------------------------------------
	logic                shot_clk_q;
	logic                shot_act_q;
	logic [CEL_TS_W-1:0] ts_q;
	logic [CEL_TS_W-1:0] ts_d;
	wire                 tick       = shot_clk_s & ~shot_clk_q;
	wire                 shot_start = shot_act_s & ~shot_act_q;

	// stamp restarts at each shot so it lines up with the shot data system
	assign ts_d = shot_start ? '0 : (tick ? ts_q + CEL_TS_W'(1) : ts_q);

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			shot_clk_q <= 1'b0;
			shot_act_q <= 1'b0;
			ts_q       <= '0;
		end else begin
			shot_clk_q <= shot_clk_s;
			shot_act_q <= shot_act_s;
			ts_q       <= ts_d;
		end
	end

	// ----------------------------------------
	// main service loop
	// ----------------------------------------
	cel_state_type        state_q;
	cel_state_type        state_d;
	logic [CEL_MON_W-1:0] prev_q;
	logic [CEL_REC_W-1:0] rec_q;
	logic [AW:0]          count_q;
	logic [AW:0]          count_d;
	logic                 ovf_q;
	logic                 ovf_d;
	logic                 hb_q;
	wire                  polling = (state_q == CEL_POLL);
	wire                  changed = polling && (mon != prev_q);
	wire                  full    = (count_q == DEPTH[AW:0]);
	wire                  do_wr   = (state_q == CEL_STORE) && !full;
	wire                  lost    = (state_q == CEL_STORE) && full;

	assign state_d = changed ? CEL_STORE : CEL_POLL;
	assign count_d = shot_start ? '0 : (do_wr ? count_q + (AW+1)'(1) : count_q);
	// an overflow in the cycle of a new shot still wins
	assign ovf_d   = lost | (ovf_q & ~shot_start);

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_q <= CEL_POLL;
			prev_q  <= '0;
			rec_q   <= '0;
			count_q <= '0;
			ovf_q   <= 1'b0;
			hb_q    <= 1'b0;
		end else begin
			state_q <= state_d;
			count_q <= count_d;
			ovf_q   <= ovf_d;
			if (changed) begin
				prev_q <= mon;
				rec_q  <= {ts_q, mon};
			end
			// relayed only while looping, so a stuck loop freezes it
			if (polling) begin
				hb_q <= hb_s;
			end
		end
	end

	// ----------------------------------------
	// event store and readout
	// ----------------------------------------
	cel_store_if #(.AW(AW), .RW(CEL_REC_W)) st_if ();
	logic rd_valid_q;
	// reads during a shot are refused: no valid strobe, store untouched
	wire  rd_ok = rd_en_i & ~shot_act_s;

	assign st_if.wr_en   = do_wr;
	assign st_if.wr_addr = count_q[AW-1:0];
	assign st_if.wr_data = rec_q;
	assign st_if.rd_en   = rd_ok;
	assign st_if.rd_addr = rd_addr_i;

	cel_store #(.DEPTH(DEPTH)) u_store (
		.clock_i   (clock_i),
		.sys_rst_i (sys_rst_i),
		.bus       (st_if.mem)
	);

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rd_valid_q <= 1'b0;
		end else begin
			rd_valid_q <= rd_ok;
		end
	end

	// ----------------------------------------
	// controller link
	// ----------------------------------------
	logic [CEL_LINK_W-1:0] tx_q;

	// local control bits go out while the inbound half is logged
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			tx_q <= '0;
		end else begin
			tx_q <= mon[CEL_LINK_W-1:0];
		end
	end

	assign link_tx_o     = tx_q;
	assign heartbeat_o   = hb_q;
	assign rd_valid_o    = rd_valid_q;
	assign rd_data_o     = st_if.rd_data;
	assign event_count_o = count_q;
	assign overflow_o    = ovf_q;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	localparam int DET_MAX = CEL_DETECT_CYC;
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);

	change_logs_a: assert property ($changed(mon) && !full && !shot_start |-> ##[1:DET_MAX] do_wr)
		else $error("input change not logged in time");
	detect_event_a: assert property (changed |=> state_q == CEL_STORE && prev_q == $past(mon))
		else $error("change did not start a store");
	stamp_tick_a: assert property (tick && !shot_start |=> ts_q == $past(ts_q) + 1)
		else $error("timestamp missed a shot clock edge");
	record_snap_a: assert property (changed |=> rec_q == {$past(ts_q), $past(mon)})
		else $error("record not snapshot plus stamp");
	count_order_a: assert property (do_wr && !shot_start |=> count_q == $past(count_q) + 1)
		else $error("write address did not advance");
	shot_read_a: assert property (shot_act_s && rd_en_i |=> !rd_valid_o)
		else $error("read answered during a shot");
	link_echo_a: assert property (1'b1 |-> ##1 link_tx_o == $past(mon[CEL_LINK_W-1:0]))
		else $error("link output not following local bits");
	hb_hold_a: assert property (!polling |=> $stable(heartbeat_o))
		else $error("heartbeat moved outside the loop");
	mtf_seen_a: assert property ($changed(mon[CEL_MTF_POS]) |-> changed || !polling)
		else $error("thermal fault change ignored");
	full_stop_a: assert property (lost |=> overflow_o && count_q == $past(count_q) || $past(shot_start))
		else $error("overflow not flagged when full");
	no_wr_full_a: assert property (full |-> !st_if.wr_en)
		else $error("write while store full");

	event_cov_c: cover property (do_wr ##1 changed);
	overflow_cov_c: cover property ($rose(overflow_o));
	readout_cov_c: cover property (!shot_act_s ##1 rd_valid_o [*2]);
	hb_cov_c: cover property ($rose(heartbeat_o) ##[1:20] $fell(heartbeat_o));
endmodule
`default_nettype wire

//--- test/cel_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module cel_host_model
	import cel_pkg::*;
#(
	parameter int AW = 4
)(
	// clock
	input  wire logic                 clock_i,
	// readout port
	output logic                      rd_en_o,
	output logic      [AW-1:0]        rd_addr_o,
	input  wire logic                 rd_valid_i,
	input  wire logic [CEL_REC_W-1:0] rd_data_i
);
	initial begin
		rd_en_o = 1'b0;
		rd_addr_o = '0;
	end
	// ----------------------------------------
	// one read, called both during the shot and once it is over
	// ----------------------------------------
	task automatic read_rec(input logic [AW-1:0] a, output logic [CEL_REC_W-1:0] d, output logic ok);
		@(posedge clock_i);
		rd_en_o <= 1'b1;
		rd_addr_o <= a;
		@(posedge clock_i);
		rd_en_o <= 1'b0;
		// released address shows a changing pattern, not the last one
		rd_addr_o <= ~a;
		@(posedge clock_i);
		ok = rd_valid_i;
		d = rd_data_i;
	endtask
endmodule
`default_nettype wire

//--- test/change_event_logger_tb.sv
`timescale 1ns/1ns
`default_nettype none
module change_event_logger_tb
	import cel_pkg::*;
;
	localparam int DEPTH = 16;
	localparam int AW = 4;
	logic                   clock_i, sys_rst_i, mtf_n, shot_clk, shot_act, hb_i, hb_o, rd_en, rd_valid, ovf, ok;
	logic [CEL_LOCAL_W-1:0] status;
	logic [CEL_LINK_W-1:0]  link_rx, link_tx;
	logic [AW-1:0]          rd_addr;
	logic [AW:0]            count;
	logic [CEL_REC_W-1:0]   rd_data, got;
	logic [CEL_REC_W-1:0]   exp_rec [DEPTH];
	int                     error_cnt, checks_done, cyc_cnt, ticks;

	cel_logger #(.DEPTH(DEPTH)) u_cel_logger (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .status_i(status),
		.master_thermal_fault_n_i(mtf_n), .link_rx_i(link_rx), .link_tx_o(link_tx), .shot_clk_i(shot_clk),
		.shot_active_i(shot_act), .heartbeat_i(hb_i), .heartbeat_o(hb_o), .rd_en_i(rd_en), .rd_addr_i(rd_addr),
		.rd_valid_o(rd_valid), .rd_data_o(rd_data), .event_count_o(count), .overflow_o(ovf));
	cel_host_model #(.AW(AW)) u_cel_host_model (.clock_i(clock_i), .rd_en_o(rd_en), .rd_addr_o(rd_addr),
		.rd_valid_i(rd_valid), .rd_data_i(rd_data));

	initial begin
		clock_i = 1'b0;
		forever #50 clock_i = ~clock_i;
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// thermal fault kept at pin polarity in bit 63 of the snapshot
	function automatic logic [CEL_REC_W-1:0] exp_record(input int ts, input logic [CEL_LINK_W-1:0] lnk,
		input logic flt, input logic [CEL_LOCAL_W-1:0] st);
		return {CEL_TS_W'(ts), lnk, flt, st};
	endfunction
	// count saturates at the store depth
	function automatic logic [127:0] exp_count(input int i);
		return 128'((i < DEPTH) ? i + 1 : DEPTH);
	endfunction
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clock_i);
	endtask
	// 1 MHz shot clock: ten system cycles per period
	task automatic tick;
		shot_clk <= 1'b1;
		cyc(5);
		shot_clk <= 1'b0;
		cyc(5);
		ticks++;
	endtask
	always @(posedge clock_i) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 2000) begin
			error_cnt++;
			print_verdict();
		end
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		error_cnt = 0;
		checks_done = 0;
		cyc_cnt = 0;
		ticks = 0;
		sys_rst_i = 1'b1;
		status = '0;
		mtf_n = 1'b1;
		link_rx = '0;
		shot_clk = 1'b0;
		shot_act = 1'b0;
		hb_i = 1'b0;
		void'($urandom(45221));
		cyc(8);
		sys_rst_i <= 1'b0;
		cyc(20);
		shot_act <= 1'b1;
		cyc(5);
		check("count", 128'(count), 128'h0);
		for (int i = 0; i <= DEPTH; i++) begin
			tick();
			hb_i <= 1'($urandom);
			case (i % 3)
				0: status <= (i == 0) ? ~status : status ^ (CEL_LOCAL_W'({$urandom, $urandom}) | 63'h1);
				1: link_rx <= link_rx ^ ($urandom | 32'h1);
				default: mtf_n <= ~mtf_n;
			endcase
			cyc(10);
			if (i < DEPTH)
				exp_rec[i] = exp_record(ticks, link_rx, mtf_n, status);
			check("count", 128'(count), exp_count(i));
			check("link", 128'(link_tx), 128'(status[31:0]));
			check("beat", 128'(hb_o), 128'(hb_i));
		end
		$display("event test done");
		check("ovf", 128'(ovf), 128'h1);
		u_cel_host_model.read_rec(4'h0, got, ok);
		check("refused", 128'(ok), 128'h0);
		shot_act <= 1'b0;
		cyc(5);
		for (int i = 0; i < DEPTH; i++) begin
			u_cel_host_model.read_rec(AW'(i), got, ok);
			check("valid", 128'(ok), 128'h1);
			check("rec", got, exp_rec[i]);
		end
		$display("readout test done");
		shot_act <= 1'b1;
		cyc(5);
		check("clr", 128'({count, ovf}), 128'h0);
		$display("restart test done");
		print_verdict();
	end
endmodule
`default_nettype wire
